/* File: inc/reset_strap_latch_params.svh */
`ifndef RESET_STRAP_LATCH_PARAMS_SVH
`define RESET_STRAP_LATCH_PARAMS_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define CLK_MHZ          40
`define EN_LOW_US        40
`define EN_LOW_CYC       (`EN_LOW_US * `CLK_MHZ)
`define EN_CNT_W         11
`define LAMP_SLOW_MS     500
`define LAMP_FAST_MS     125
`define LAMP_SLOW_CYC    (`LAMP_SLOW_MS * `CLK_MHZ * 1000)
`define LAMP_FAST_CYC    (`LAMP_FAST_MS * `CLK_MHZ * 1000)
`define BLINK_CNT_W      25

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define OFS_STATUS       8'h00
`define OFS_IRQ_STATUS   8'h04
`define OFS_IRQ_MASK     8'h08
`define OFS_LAMP_CTRL    8'h0c
`define OFS_TARGET_ADDR  8'h10

// ****************************************************************
// field positions and values
// ****************************************************************
`define IRQ_W            3
`define IRQ_LATCHED      0
`define IRQ_PIN_RESET    1
`define IRQ_POWER_LOSS   2
`define LAMP_MODE_W      3
`define LAMP_AUTO        3'h0
`define LAMP_MODE_DARK   3'h1
`define LAMP_MODE_LIT    3'h2
`define LAMP_MODE_SLOW   3'h3
`define LAMP_MODE_FAST   3'h4
// arbitrary upper part of the serial target address
`define ADDR_BASE        6'h2a
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`define SEL_NONE         3'h7
`define PIN_N            6

`endif

/* File: inc/reset_strap_latch_pkg.sv */
`default_nettype none
package reset_strap_latch_pkg;
  `include "reset_strap_latch_params.svh"

  typedef enum logic [1:0] {ST_POWERUP, ST_RUN, ST_PINRST} dev_state_t;
  typedef enum logic [1:0] {LAMP_DARK, LAMP_LIT, LAMP_SLOW, LAMP_FAST} lamp_pat_t;

  typedef struct packed {
    logic [`PIN_N-1:0][1:0]  sync;
    dev_state_t              dev;
    logic [`EN_CNT_W-1:0]    en_low_cnt;
    logic                    cadence_en;
    logic                    legacy_en;
    logic                    ac_dsc_en;
    logic                    dev_rst;
    logic [6:0]              target;
    logic [`IRQ_W-1:0]       irq_stat;
    logic [`IRQ_W-1:0]       irq_mask;
    logic [`LAMP_MODE_W-1:0] lamp_mode;
    lamp_pat_t               lamp_pat;
    logic                    irq;
    logic                    int_out;
    logic                    int_oe_n;
    logic                    lamp_out;
    logic                    lamp_oe_n;
    logic                    aw_got;
    logic                    w_got;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic [7:0]              awaddr;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    arready;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [31:0]             rdata;
  } top_state_t;

  typedef struct packed {
    logic [`BLINK_CNT_W-1:0] cnt;
    logic                    phase;
    logic                    lit;
  } blink_state_t;
endpackage : reset_strap_latch_pkg
`default_nettype wire

/* File: inc/lamp_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface lamp_if;
  import reset_strap_latch_pkg::*;
  lamp_pat_t pattern;
  logic      lit;
  modport ctrl    (output pattern, input lit);
  modport blinker (input pattern, output lit);
endinterface : lamp_if
`default_nettype wire

/* File: rtl/lamp_blinker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "reset_strap_latch_params.svh"
module lamp_blinker #(
  parameter int unsigned SLOW_HALF_CYC = `LAMP_SLOW_CYC,
  parameter int unsigned FAST_HALF_CYC = `LAMP_FAST_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  lamp_if.blinker   lb
);
  import reset_strap_latch_pkg::*;

  blink_state_t            q;
  blink_state_t            n;
  logic [`BLINK_CNT_W-1:0] half;

  assign lb.lit = q.lit;

  always_comb
  begin
    n    = q;
    half = (lb.pattern == LAMP_FAST) ? FAST_HALF_CYC[`BLINK_CNT_W-1:0] : SLOW_HALF_CYC[`BLINK_CNT_W-1:0];
    if (q.cnt >= half - `BLINK_CNT_W'(1))
    begin
      n.cnt   = '0;
      n.phase = ~q.phase;
    end
    else
    begin
      n.cnt = q.cnt + `BLINK_CNT_W'(1);
    end
    case (lb.pattern)
      LAMP_DARK: n.lit = 1'b0;
      LAMP_LIT:  n.lit = 1'b1;
      LAMP_SLOW: n.lit = q.phase;
      LAMP_FAST: n.lit = q.phase;
      default:   n.lit = 1'b0;
    endcase
    if (!aresetn)
    begin
      n = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    q <= n;
  end
endmodule : lamp_blinker
`default_nettype wire

/* File: rtl/reset_strap_latch.sv */
// Functional notes
// - enable held low for at least 40 us puts the device into its reset state.
// - an open enable pin reads high through the pad pull-up and means run.
// - the rising edge of enable that ends a reset captures the three straps.
// - legacy probing is enabled when its strap was high at capture, else disabled.
// - disconnect select low gives dc load-removal sensing, a capacitor (high) gives ac sensing.
// - the straps are also captured when power-up reset ends.
// - the open-drain interrupt pin is pulled low while an interrupt is signalled.
// - the address-select level is the low bit of the serial target address.
// - the lamp pin shows distinct blink patterns for different conditions.
// - cadence collision avoidance is enabled when its strap was high at capture.
// - the pin-driven reset ends as soon as enable returns high.
// - strap changes after capture are ignored until the next reset ends.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "reset_strap_latch_params.svh"
module reset_strap_latch #(
  parameter int unsigned SLOW_HALF_CYC = `LAMP_SLOW_CYC,
  parameter int unsigned FAST_HALF_CYC = `LAMP_FAST_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        power_good,
  input  wire logic        enable_pin,
  input  wire logic        cadence_strap,
  input  wire logic        legacy_strap,
  input  wire logic        disconnect_select_strap,
  input  wire logic        addr_select_pin,
  output var  logic        device_reset,
  output var  logic        cadence_en,
  output var  logic        legacy_probe_en,
  output var  logic        ac_disconnect_en,
  output var  logic [6:0]  target_addr,
  output var  logic        irq,
  output var  logic        int_out,
  output var  logic        int_oe_n,
  output var  logic        lamp_out,
  output var  logic        lamp_oe_n,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import reset_strap_latch_pkg::*;

  // ****************************************************************
  // pin synchroniser slots
  // ****************************************************************
  localparam int PG  = 0;
  localparam int EN  = 1;
  localparam int CAD = 2;
  localparam int LEG = 3;
  localparam int DSC = 4;
  localparam int ADR = 5;

  top_state_t        q;
  top_state_t        n;
  logic [`PIN_N-1:0] pins;
  logic [`PIN_N-1:0] pin_s;
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              leave_reset;
  logic [2:0]        wsel;
  logic [2:0]        rsel;
  logic [31:0]       cur;
  logic [31:0]       upd;
  logic [`IRQ_W-1:0] ev;

  lamp_if lamp ();

  lamp_blinker #(
    .SLOW_HALF_CYC (SLOW_HALF_CYC),
    .FAST_HALF_CYC (FAST_HALF_CYC)
  ) u_blinker (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lb      (lamp.blinker)
  );

  assign lamp.pattern = q.lamp_pat;

  // ****************************************************************
  // register decode and byte-lane merge
  // ****************************************************************
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    case (addr)
      `OFS_STATUS:      reg_sel = 3'h0;
      `OFS_IRQ_STATUS:  reg_sel = 3'h1;
      `OFS_IRQ_MASK:    reg_sel = 3'h2;
      `OFS_LAMP_CTRL:   reg_sel = 3'h3;
      `OFS_TARGET_ADDR: reg_sel = 3'h4;
      default:          reg_sel = `SEL_NONE;
    endcase
  endfunction : reg_sel

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  function automatic logic [31:0] read_word(input top_state_t s, input logic [2:0] sel);
    case (sel)
      3'h0:    read_word = {24'h000000, s.sync[ADR][1], s.sync[EN][1], s.dev, s.dev_rst,
                            s.ac_dsc_en, s.legacy_en, s.cadence_en};
      3'h1:    read_word = {29'h00000000, s.irq_stat};
      3'h2:    read_word = {29'h00000000, s.irq_mask};
      3'h3:    read_word = {29'h00000000, s.lamp_mode};
      3'h4:    read_word = {25'h0000000, s.target};
      default: read_word = 32'h00000000;
    endcase
  endfunction : read_word

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb
  begin
    n           = q;
    pins        = {addr_select_pin, disconnect_select_strap, legacy_strap, cadence_strap, enable_pin, power_good};
    leave_reset = 1'b0;
    wsel        = `SEL_NONE;
    rsel        = `SEL_NONE;
    cur         = 32'h00000000;
    upd         = 32'h00000000;
    ev          = '0;

    // two-stage synchronisers, stage one feeds only stage two
    for (int i = 0; i < `PIN_N; i++)
    begin
      n.sync[i] = {q.sync[i][0], pins[i]};
      pin_s[i]  = q.sync[i][1];
    end

    // reset sequencing
    case (q.dev)
      ST_POWERUP:
      begin
        if (pin_s[PG])
        begin
          leave_reset = 1'b1;
          n.dev       = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (!pin_s[PG])
        begin
          n.dev                     = ST_POWERUP;
          ev[`IRQ_POWER_LOSS]         = 1'b1;
        end
        else if (pin_s[EN])
        begin
          n.en_low_cnt = '0;
        end
        else if (q.en_low_cnt >= `EN_CNT_W'(`EN_LOW_CYC - 1))
        begin
          n.dev                      = ST_PINRST;
          n.en_low_cnt               = '0;
          ev[`IRQ_PIN_RESET]         = 1'b1;
        end
        else
        begin
          n.en_low_cnt = q.en_low_cnt + `EN_CNT_W'(1);
        end
      end
      ST_PINRST:
      begin
        if (!pin_s[PG])
        begin
          n.dev = ST_POWERUP;
        end
        else if (pin_s[EN])
        begin
          leave_reset = 1'b1;
          n.dev       = ST_RUN;
        end
      end
      default:
      begin
        n.dev = ST_POWERUP;
      end
    endcase
    n.dev_rst = (n.dev != ST_RUN);

    // straps are sampled only when a reset ends
    if (leave_reset)
    begin
      n.cadence_en              = pin_s[CAD];
      n.legacy_en               = pin_s[LEG];
      n.ac_dsc_en               = pin_s[DSC];
      ev[`IRQ_LATCHED]          = 1'b1;
    end

    n.target = {`ADDR_BASE, pin_s[ADR]};

    // ****************************************************************
    // axi4-lite write channel
    // ****************************************************************
    aw_hs = s_axi_awvalid && q.awready;
    w_hs  = s_axi_wvalid && q.wready;
    if (aw_hs)
    begin
      n.aw_got = 1'b1;
      // an address beyond the map parks on an unmapped offset
      n.awaddr = (s_axi_awaddr[31:8] == 24'h000000) ? {s_axi_awaddr[7:2], 2'b00} : 8'hfc;
    end
    if (w_hs)
    begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
    begin
      n.bvalid = 1'b0;
    end
    if (n.aw_got && n.w_got && !q.bvalid)
    begin
      wsel     = reg_sel(n.awaddr);
      cur      = read_word(q, wsel);
      upd      = merge(cur, n.wdata, n.wstrb);
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = (wsel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      case (wsel)
        3'h1:
        begin
          // write one clears on a strobed lane; events merged below so a set wins
          n.irq_stat = q.irq_stat & ~(n.wdata[`IRQ_W-1:0] & {`IRQ_W{n.wstrb[0]}});
        end
        3'h2:    n.irq_mask  = upd[`IRQ_W-1:0];
        3'h3:    n.lamp_mode = upd[`LAMP_MODE_W-1:0];
        default: n.bresp     = n.bresp;
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;

    // ****************************************************************
    // axi4-lite read channel
    // ****************************************************************
    ar_hs = s_axi_arvalid && q.arready;
    if (q.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
    end
    if (ar_hs)
    begin
      rsel     = (s_axi_araddr[31:8] == 24'h000000) ? reg_sel({s_axi_araddr[7:2], 2'b00}) : `SEL_NONE;
      n.rdata  = read_word(q, rsel);
      n.rresp  = (rsel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      n.rvalid = 1'b1;
    end
    n.arready = !n.rvalid;

    // ****************************************************************
    // interrupt pin
    // ****************************************************************
    n.irq_stat = n.irq_stat | ev;
    n.irq      = |(n.irq_stat & n.irq_mask);
    n.int_out  = 1'b0;
    n.int_oe_n = ~n.irq;

    // ****************************************************************
    // status lamp
    // ****************************************************************
    case (q.lamp_mode)
      `LAMP_MODE_DARK: n.lamp_pat = LAMP_DARK;
      `LAMP_MODE_LIT:  n.lamp_pat = LAMP_LIT;
      `LAMP_MODE_SLOW: n.lamp_pat = LAMP_SLOW;
      `LAMP_MODE_FAST: n.lamp_pat = LAMP_FAST;
      default:
      begin
        // auto: fast in reset, slow with a pending interrupt, steady when running
        if (q.dev_rst)
        begin
          n.lamp_pat = LAMP_FAST;
        end
        else if (q.irq)
        begin
          n.lamp_pat = LAMP_SLOW;
        end
        else
        begin
          n.lamp_pat = LAMP_LIT;
        end
      end
    endcase
    n.lamp_out  = 1'b0;
    n.lamp_oe_n = ~lamp.lit;

    // ****************************************************************
    // synchronous reset values
    // ****************************************************************
    if (!aresetn)
    begin
      n            = '0;
      n.dev        = ST_POWERUP;
      n.dev_rst    = 1'b1;
      n.cadence_en = 1'b1;
      n.legacy_en  = 1'b1;
      n.ac_dsc_en  = 1'b1;
      n.target     = {`ADDR_BASE, 1'b0};
      n.lamp_mode  = `LAMP_AUTO;
      n.lamp_pat   = LAMP_DARK;
      n.int_oe_n   = 1'b1;
      n.lamp_oe_n  = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    q <= n;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign device_reset     = q.dev_rst;
  assign cadence_en       = q.cadence_en;
  assign legacy_probe_en  = q.legacy_en;
  assign ac_disconnect_en = q.ac_dsc_en;
  assign target_addr      = q.target;
  assign irq              = q.irq;
  assign int_out          = q.int_out;
  assign int_oe_n         = q.int_oe_n;
  assign lamp_out         = q.lamp_out;
  assign lamp_oe_n        = q.lamp_oe_n;
  assign s_axi_awready    = q.awready;
  assign s_axi_wready     = q.wready;
  assign s_axi_bvalid     = q.bvalid;
  assign s_axi_bresp      = q.bresp;
  assign s_axi_arready    = q.arready;
  assign s_axi_rvalid     = q.rvalid;
  assign s_axi_rresp      = q.rresp;
  assign s_axi_rdata      = q.rdata;
endmodule : reset_strap_latch
`default_nettype wire

/* File: test/reset_strap_latch_sva.sv */
`timescale 1ns/10ps
`default_nettype none
`include "reset_strap_latch_params.svh"
module strap_latch_checker #(
  parameter int unsigned SLOW_HALF_CYC = 8,
  parameter int unsigned FAST_HALF_CYC = 4
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       power_good,
  input wire logic       enable_pin,
  input wire logic       cadence_strap,
  input wire logic       legacy_strap,
  input wire logic       disconnect_select_strap,
  input wire logic       addr_select_pin,
  input wire logic       device_reset,
  input wire logic       cadence_en,
  input wire logic       legacy_probe_en,
  input wire logic       ac_disconnect_en,
  input wire logic [6:0] target_addr,
  input wire logic       irq,
  input wire logic       int_out,
  input wire logic       int_oe_n,
  input wire logic       lamp_out,
  input wire logic       lamp_oe_n
);
  localparam int EN_LIM = `EN_LOW_CYC;
  logic [11:0] low_cnt_ff;
  logic [11:0] nxt_low_cnt;
  wire  [2:0]  strap_v = {cadence_strap, legacy_strap, disconnect_select_strap};
  wire  [2:0]  en_v    = {cadence_en, legacy_probe_en, ac_disconnect_en};
  // ********************************
  // run length of enable held low
  // ********************************
  always_comb nxt_low_cnt = enable_pin ? 12'h000 : low_cnt_ff + {11'h000, low_cnt_ff != 12'hfff};
  always_ff @(posedge aclk) low_cnt_ff <= aresetn ? nxt_low_cnt : 12'h000;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_pg_steady; power_good [*6]; endsequence
  sequence s_en_rise; device_reset && power_good && $rose(enable_pin); endsequence
  sequence s_leave; $fell(device_reset) && strap_v == $past(strap_v, 6); endsequence
  property p_enter; power_good && low_cnt_ff == EN_LIM + 6 |-> device_reset; endproperty
  property p_early; s_pg_steady ##0 $rose(device_reset) |-> low_cnt_ff >= EN_LIM + 1; endproperty
  property p_exit; s_en_rise |-> ##[1:5] !device_reset; endproperty
  property p_capture; s_leave |-> ##[0:1] en_v == strap_v; endproperty
  property p_hold; !device_reset [*3] |-> $stable(en_v); endproperty
  property p_addr; $stable(addr_select_pin) [*4] |-> target_addr == {`ADDR_BASE, addr_select_pin}; endproperty
  property p_int; int_oe_n == !irq && !int_out; endproperty
  property p_lamp; device_reset [*8] |-> ##[0:10] ($changed(lamp_oe_n) && !lamp_out); endproperty
  a_enter: assert property (p_enter) else $error("no reset after long low enable");
  a_early: assert property (p_early) else $error("reset entered too early");
  a_exit: assert property (p_exit) else $error("reset not left after enable rise");
  a_capture: assert property (p_capture) else $error("strap capture wrong");
  a_hold: assert property (p_hold) else $error("captured strap changed in run");
  a_addr: assert property (p_addr) else $error("target address wrong");
  a_int: assert property (p_int) else $error("interrupt pin wrong");
  a_lamp: assert property (p_lamp) else $error("lamp not blinking in reset");
endmodule : strap_latch_checker
bind reset_strap_latch strap_latch_checker #(.SLOW_HALF_CYC(SLOW_HALF_CYC), .FAST_HALF_CYC(FAST_HALF_CYC)) u_chk (
  .aclk, .aresetn, .power_good, .enable_pin, .cadence_strap, .legacy_strap, .disconnect_select_strap,
  .addr_select_pin, .device_reset, .cadence_en, .legacy_probe_en, .ac_disconnect_en, .target_addr, .irq,
  .int_out, .int_oe_n, .lamp_out, .lamp_oe_n);
`default_nettype wire

/* File: test/strap_board.sv */
`timescale 1ns/10ps
`default_nettype none
module strap_board (
  input  wire logic en_low,
  input  wire logic cad_low,
  input  wire logic leg_low,
  input  wire logic cap_gone,
  input  wire logic addr_hi,
  input  wire logic int_out,
  input  wire logic int_oe_n,
  input  wire logic lamp_out,
  input  wire logic lamp_oe_n,
  output wire logic enable_pin,
  output wire logic cadence_strap,
  output wire logic legacy_strap,
  output wire logic disconnect_select_strap,
  output wire logic addr_select_pin,
  output wire logic int_line,
  output wire logic lamp_line
);
  // ********************************
  // pull-ups, strap ties and open-drain lines
  // ********************************
  assign enable_pin = !en_low;
  assign cadence_strap = !cad_low;
  assign legacy_strap = !leg_low;
  assign disconnect_select_strap = !cap_gone;
  assign addr_select_pin = addr_hi;
  assign int_line = int_oe_n ? 1'b1 : int_out;
  assign lamp_line = lamp_oe_n ? 1'b1 : lamp_out;
endmodule : strap_board
`default_nettype wire

/* File: test/reset_strap_latch_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "reset_strap_latch_params.svh"
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); \
    end \
  end
module reset_strap_latch_bench;
  localparam int SLOW = 8;
  localparam int FAST = 4;
  logic        aclk, aresetn, power_good, en_low, cad_low, leg_low, cap_gone, addr_hi, irq;
  logic        enable_pin, cadence_strap, legacy_strap, disconnect_select_strap, addr_select_pin;
  logic        device_reset, cadence_en, legacy_probe_en, ac_disconnect_en;
  logic        int_out, int_oe_n, lamp_out, lamp_oe_n, int_line, lamp_line;
  logic [6:0]  target_addr;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          num_errors = 0;
  int          n_compared = 0;

  reset_strap_latch #(.SLOW_HALF_CYC(SLOW), .FAST_HALF_CYC(FAST)) u_dut (
    .aclk, .aresetn, .power_good, .enable_pin, .cadence_strap, .legacy_strap, .disconnect_select_strap,
    .addr_select_pin, .device_reset, .cadence_en, .legacy_probe_en, .ac_disconnect_en, .target_addr, .irq,
    .int_out, .int_oe_n, .lamp_out, .lamp_oe_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  strap_board u_board (.en_low, .cad_low, .leg_low, .cap_gone, .addr_hi, .int_out, .int_oe_n, .lamp_out,
    .lamp_oe_n, .enable_pin, .cadence_strap, .legacy_strap, .disconnect_select_strap, .addr_select_pin,
    .int_line, .lamp_line);

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ********************************
  // bus cycles and waits
  // ********************************
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic give_up(input logic hit);
    if (hit)
    begin
      num_errors++;
      $display("MISMATCH t=%0t wait ran out", $time);
      summarize();
    end
  endtask : give_up
  task automatic wait_rst(input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && device_reset !== lvl; i++) @(posedge aclk);
    give_up(device_reset !== lvl);
  endtask : wait_rst
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic pa;
    logic pw;
    int   k;
    pa = 1'b1;
    pw = 1'b1;
    k = 0;
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while ((pa || pw) && k < 50)
    begin
      @(posedge aclk);
      k++;
      if (pa && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (pw && s_axi_wready) s_axi_wvalid <= 1'b0;
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
    end
    give_up(pa || pw);
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    for (k = 0; k < 50 && s_axi_bvalid !== 1'b1; k++) @(posedge aclk);
    give_up(s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int k;
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    @(posedge aclk);
    for (k = 0; k < 50 && s_axi_arready !== 1'b1; k++) @(posedge aclk);
    give_up(s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    for (k = 0; k < 50 && s_axi_rvalid !== 1'b1; k++) @(posedge aclk);
    give_up(s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  // ********************************
  // scenarios
  // ********************************
  task automatic t_powerup;
    repeat (4) @(posedge aclk);
    power_good <= 1'b1;
    wait_rst(1'b0, 20);
    repeat (2) @(posedge aclk);
    `CHK({cadence_en, legacy_probe_en, ac_disconnect_en}, 3'b010)
    axr(`OFS_STATUS, d, r);
    `CHK(d[3:0], 4'h2)
    $display("test powerup done");
  endtask : t_powerup
  task automatic t_pin;
    en_low <= 1'b1;
    repeat (`EN_LOW_CYC - 20) @(posedge aclk);
    en_low <= 1'b0;
    repeat (10) @(posedge aclk);
    `CHK(device_reset, 1'b0)
    en_low <= 1'b1;
    cad_low <= 1'b0;
    leg_low <= 1'b1;
    cap_gone <= 1'b0;
    repeat (`EN_LOW_CYC - 4) @(posedge aclk);
    `CHK(device_reset, 1'b0)
    wait_rst(1'b1, 20);
    repeat (8) @(posedge aclk);
    en_low <= 1'b0;
    wait_rst(1'b0, 8);
    repeat (2) @(posedge aclk);
    `CHK({cadence_en, legacy_probe_en, ac_disconnect_en}, 3'b101)
    cad_low <= 1'b1;
    leg_low <= 1'b0;
    repeat (10) @(posedge aclk);
    `CHK({cadence_en, legacy_probe_en}, 2'b10)
    $display("test pin reset done");
  endtask : t_pin
  task automatic t_addr;
    for (int v = 0; v < 2; v++)
    begin
      addr_hi <= v[0];
      repeat (6) @(posedge aclk);
      `CHK(target_addr, {`ADDR_BASE, v[0]})
      axw(`OFS_TARGET_ADDR, 32'h0, r);
      `CHK(r, `RESP_OKAY)
      axr(`OFS_TARGET_ADDR, d, r);
      `CHK(d[6:0], {`ADDR_BASE, v[0]})
    end
    $display("test address done");
  endtask : t_addr
  task automatic t_irq;
    axr(`OFS_IRQ_STATUS, d, r);
    `CHK(d[2:0], 3'h3)
    axw(`OFS_IRQ_MASK, 32'h2, r);
    repeat (3) @(posedge aclk);
    `CHK({irq, int_line}, 2'b10)
    axw(`OFS_IRQ_STATUS, 32'h2, r);
    repeat (3) @(posedge aclk);
    `CHK({irq, int_line}, 2'b01)
    axr(8'h20, d, r);
    `CHK(r, `RESP_SLVERR)
    $display("test interrupt done");
  endtask : t_irq
  task automatic t_loss;
    power_good <= 1'b0;
    wait_rst(1'b1, 8);
    power_good <= 1'b1;
    wait_rst(1'b0, 8);
    `CHK({cadence_en, legacy_probe_en, ac_disconnect_en}, 3'b011)
    axr(`OFS_IRQ_STATUS, d, r);
    `CHK(d[2:0], 3'h5)
    $display("test power loss done");
  endtask : t_loss
  task automatic t_lamp;
    int n;
    int ex;
    logic lv;
    for (int m = 1; m < 5; m++)
    begin
      axw(`OFS_LAMP_CTRL, m, r);
      repeat (8) @(posedge aclk);
      n = 0;
      lv = lamp_line;
      ex = (m < 3) ? 0 : 64 / ((m == 3) ? SLOW : FAST);
      repeat (64)
      begin
        @(posedge aclk);
        n += int'(lamp_line !== lv);
        lv = lamp_line;
      end
      `CHK(n >= ex - 1 && n <= ex + 1, 1'b1)
      if (m < 3) `CHK(lamp_line, m == 1)
    end
    axw(`OFS_LAMP_CTRL, 32'h0, r);
    repeat (8) @(posedge aclk);
    `CHK(lamp_line, 1'b0)
    $display("test lamp done");
  endtask : t_lamp

  initial
  begin
    {aresetn, power_good, en_low, leg_low, addr_hi} = 5'h00;
    {cad_low, cap_gone} = 2'h3;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_powerup();
    t_pin();
    t_addr();
    t_irq();
    t_loss();
    t_lamp();
    summarize();
  end
endmodule : reset_strap_latch_bench
`default_nettype wire
